// file: rtl/pmon_pkg.sv
package pmon_pkg;
   // register offsets of the count block
   localparam logic [7:0] OFS_STATUS    = 8'h58;
   localparam logic [7:0] OFS_FRAMING   = 8'h59;
   localparam logic [7:0] OFS_FLB_LOW   = 8'h5A;
   localparam logic [7:0] OFS_FLB_HIGH  = 8'h5B;
   localparam logic [7:0] OFS_BCE_LOW   = 8'h5C;
   localparam logic [7:0] OFS_BCE_HIGH  = 8'h5D;
   localparam logic [7:0] OFS_VIOL_LOW  = 8'h5E;
   localparam logic [7:0] OFS_VIOL_HIGH = 8'h5F;
   localparam logic [7:0] OFS_GLOBAL    = 8'h0D;
   // status register field positions
   localparam int BIT_IRQ_ENABLE = 2;
   localparam int BIT_TRANSFER   = 1;
   localparam int BIT_OVERRUN    = 0;
   // counter widths
   localparam int FRAMING_W = 7;
   localparam int FLB_W     = 10;
   localparam int BCE_W     = 10;
   localparam int VIOL_W    = 13;
   // latch delay: three recovered clock periods, under the 3.5 limit
   localparam int LATCH_CYCLES = 3;
   localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// file: rtl/pmon_evt_if.sv
`timescale 1ns/100ps
interface pmon_evt_if;
   logic inc;    // qualified event pulse
   logic clear;  // restart the interval
   logic [15:0] count;
   modport src (output inc, output clear, input count);
   modport cnt (input inc, input clear, output count);
endinterface

// file: rtl/sat_counter.sv
`timescale 1ns/100ps
module sat_counter #(
   parameter int W = 10
) (
   input  wire logic mclk_in,
   input  wire logic rstn_in,
   pmon_evt_if.cnt   ev
);
   logic [W-1:0] cnt_reg;

   // clear restarts at one when an event coincides, so none is lost
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_reg <= '0;
      end else if (ev.clear) begin
         cnt_reg <= ev.inc ? W'(1) : '0;
      end else if (ev.inc && cnt_reg != {W{1'b1}}) begin
         cnt_reg <= cnt_reg + W'(1);
      end
   end

   assign ev.count = 16'(cnt_reg);

   a_sat_hold : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      ($past(cnt_reg) == {W{1'b1}} && !$past(ev.clear)) |-> cnt_reg == {W{1'b1}})
      else $error("counter wrapped past maximum");
   a_clear_keep : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (ev.clear && ev.inc) |=> cnt_reg == W'(1))
      else $error("event lost at interval restart");
endmodule

// file: rtl/pmon_counters.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - seven bit framing error tally, readable count of previous interval
// - framing errors ignored when E1 out of frame or T1 not in frame
// - T1 framing error pulse covers Fe, SF, Ft and T1DM F-bit errors
// - E1 counts errored alignment bits, or whole errored words on option
// - option counts zero in bit 2 of slot 0 of non-alignment frames
// - T1 shared ten bit count selects frame loss or alignment change
// - alignment change counted only when new alignment differs
// - E1 shared count takes far end block errors, ignored out of frame
// - shared count split low byte and two bits of high register
// - T1 bit error tally counts up to seven errors per frame
// - E1 counts CRC errors, ignored out of multiframe alignment
// - thirteen bit line code violation count, split low and high bytes
// - configuration bit can drop excessive zeros from violation count
// - write to one count address or global update latches and clears all
// - holding registers loaded within 3.5 recovered clock periods
// - count registers undefined until first latch after reset; here the holding registers reset to zero
// - latch sets transfer flag; latch while set sets overrun; read clears
module pmon_counters (
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   input  wire logic       e1_mode_in,
   input  wire logic       frame_loss_flag_in,
   input  wire logic       in_frame_flag_in,
   input  wire logic       multiframe_loss_flag_in,
   input  wire logic       fas_bit_err_in,
   input  wire logic [1:0] fas_bit_err_cnt_in,
   input  wire logic       fas_word_err_in,
   input  wire logic       fas_word_select_in,
   input  wire logic       nfas_bit2_zero_in,
   input  wire logic       nfas_bit2_count_in,
   input  wire logic       t1_frame_bit_err_in,
   input  wire logic       count_alignment_change_select_in,
   input  wire logic       reframe_event_in,
   input  wire logic       alignment_change_event_in,
   input  wire logic       far_block_error_in,
   input  wire logic [2:0] t1_bit_err_cnt_in,
   input  wire logic       crc_err_in,
   input  wire logic       bipolar_violation_in,
   input  wire logic       excess_zero_in,
   input  wire logic       excess_zero_count_disable_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   output logic            transfer_irq_out
);
   ////////////////////////////////////////////////////////////////////////////
   localparam int FRAMING_W = pmon_pkg::FRAMING_W;
   localparam int FLB_W     = pmon_pkg::FLB_W;
   localparam int BCE_W     = pmon_pkg::BCE_W;
   localparam int VIOL_W    = pmon_pkg::VIOL_W;
   logic                 flb_inc_reg, viol_inc_reg;
   logic [2:0]           frame_amt_reg, bce_amt_reg;
   logic                 latch_pend_reg;
   logic [1:0]           latch_cnt_reg;
   logic                 latch_go;
   logic                 transfer_done_flag_reg;
   logic                 holding_overrun_flag_reg;
   logic                 transfer_interrupt_enable_reg;
   logic [FRAMING_W-1:0] framing_error_tally_reg;
   logic [BCE_W-1:0]     bit_crc_tally_reg;
   logic [FLB_W-1:0]     frame_loss_far_tally_reg;
   logic [VIOL_W-1:0]    line_code_violation_tally_reg;
   logic [FLB_W-1:0]     hold_flb_reg;
   logic [VIOL_W-1:0]    hold_viol_reg;
   logic [FRAMING_W-1:0] hold_frame_reg;
   logic [BCE_W-1:0]     hold_bce_reg;
   logic                 count_wr;

   pmon_evt_if flb_ev ();
   pmon_evt_if viol_ev ();

   ////////////////////////////////////////////////////////////////////////////
   // event qualification, one cycle of pipeline
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         frame_amt_reg <= 3'h0;
         flb_inc_reg   <= 1'b0;
         viol_inc_reg  <= 1'b0;
         bce_amt_reg   <= 3'h0;
      end else begin
         if (e1_mode_in) begin
            if (frame_loss_flag_in) begin
               frame_amt_reg <= 3'h0;
            end else begin
               frame_amt_reg <= (fas_word_select_in ? {2'h0, fas_word_err_in}
                                : {1'b0, fas_bit_err_cnt_in & {2{fas_bit_err_in}}})
                                + {2'h0, nfas_bit2_count_in & nfas_bit2_zero_in};
            end
            flb_inc_reg <= far_block_error_in & ~frame_loss_flag_in;
            bce_amt_reg <= {2'h0, crc_err_in & ~multiframe_loss_flag_in};
         end else begin
            frame_amt_reg <= {2'h0, t1_frame_bit_err_in & in_frame_flag_in};
            flb_inc_reg <= count_alignment_change_select_in ?
                           alignment_change_event_in : reframe_event_in;
            bce_amt_reg <= t1_bit_err_cnt_in;
         end
         viol_inc_reg <= bipolar_violation_in |
                         (excess_zero_in & ~excess_zero_count_disable_in);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // multi-step counters, saturating
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         framing_error_tally_reg <= '0;
         bit_crc_tally_reg       <= '0;
      end else if (latch_go) begin
         framing_error_tally_reg <= FRAMING_W'(frame_amt_reg);
         bit_crc_tally_reg       <= BCE_W'(bce_amt_reg);
      end else begin
         framing_error_tally_reg <= sat_add_frame(framing_error_tally_reg, frame_amt_reg);
         bit_crc_tally_reg       <= sat_add_bce(bit_crc_tally_reg, bce_amt_reg);
      end
   end

   function automatic logic [FRAMING_W-1:0] sat_add_frame(input logic [FRAMING_W-1:0] a,
                                                          input logic [2:0]           b);
      logic [FRAMING_W:0] s;
      s = {1'b0, a} + (FRAMING_W+1)'(b);
      return s[FRAMING_W] ? {FRAMING_W{1'b1}} : s[FRAMING_W-1:0];
   endfunction

   function automatic logic [BCE_W-1:0] sat_add_bce(input logic [BCE_W-1:0] a,
                                                    input logic [2:0] b);
      logic [BCE_W:0] s;
      s = {1'b0, a} + (BCE_W+1)'(b);
      return s[BCE_W] ? {BCE_W{1'b1}} : s[BCE_W-1:0];
   endfunction

   // single-step counters through the shared counter module
   assign flb_ev.inc   = flb_inc_reg;
   assign flb_ev.clear = latch_go;
   assign viol_ev.inc   = viol_inc_reg;
   assign viol_ev.clear = latch_go;

   sat_counter #(.W(FLB_W)) u_flb (
      .mclk_in (mclk_in),
      .rstn_in (rstn_in),
      .ev      (flb_ev.cnt)
   );
   sat_counter #(.W(VIOL_W)) u_viol (
      .mclk_in (mclk_in),
      .rstn_in (rstn_in),
      .ev      (viol_ev.cnt)
   );
   assign frame_loss_far_tally_reg      = flb_ev.count[FLB_W-1:0];
   assign line_code_violation_tally_reg = viol_ev.count[VIOL_W-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // latch request: any write to a count address or the global update
   assign count_wr = wr_in && ((addr_in >= pmon_pkg::OFS_FRAMING
                                && addr_in <= pmon_pkg::OFS_VIOL_HIGH)
                     || addr_in == pmon_pkg::OFS_GLOBAL);

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         latch_pend_reg <= 1'b0;
         latch_cnt_reg  <= 2'h0;
      end else if (count_wr && !latch_pend_reg) begin
         latch_pend_reg <= 1'b1;
         latch_cnt_reg  <= 2'(pmon_pkg::LATCH_CYCLES - 1);
      end else if (latch_pend_reg) begin
         if (latch_cnt_reg == 2'h0) begin
            latch_pend_reg <= 1'b0;
         end else begin
            latch_cnt_reg <= latch_cnt_reg - 2'h1;
         end
      end
   end
   assign latch_go = latch_pend_reg && latch_cnt_reg == 2'h0;

   // holding registers, loaded in the same cycle the counters restart
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         hold_frame_reg <= '0;
         hold_flb_reg   <= '0;
         hold_bce_reg   <= '0;
         hold_viol_reg  <= '0;
      end else if (latch_go) begin
         hold_frame_reg <= framing_error_tally_reg;
         hold_flb_reg   <= frame_loss_far_tally_reg;
         hold_bce_reg   <= bit_crc_tally_reg;
         hold_viol_reg  <= line_code_violation_tally_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags: a latch wins over the clearing read
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         transfer_done_flag_reg   <= 1'b0;
         holding_overrun_flag_reg <= 1'b0;
      end else begin
         if (latch_go) begin
            transfer_done_flag_reg <= 1'b1;
         end else if (rd_in && addr_in == pmon_pkg::OFS_STATUS) begin
            transfer_done_flag_reg <= 1'b0;
         end
         if (latch_go && transfer_done_flag_reg) begin
            holding_overrun_flag_reg <= 1'b1;
         end else if (rd_in && addr_in == pmon_pkg::OFS_STATUS) begin
            holding_overrun_flag_reg <= 1'b0;
         end
      end
   end

   // interrupt enable, written through the status address
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         transfer_interrupt_enable_reg <= 1'b0;
      end else if (wr_in && addr_in == pmon_pkg::OFS_STATUS) begin
         transfer_interrupt_enable_reg <= wdata_in[pmon_pkg::BIT_IRQ_ENABLE];
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         transfer_irq_out <= 1'b0;
      end else begin
         transfer_irq_out <= transfer_interrupt_enable_reg && transfer_done_flag_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered read data, one cycle after the read strobe
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= pmon_pkg::RESET_BYTE;
      end else if (rd_in) begin
         unique case (addr_in)
            pmon_pkg::OFS_STATUS:   rdata_out <= {5'h00, transfer_interrupt_enable_reg,
                                               transfer_done_flag_reg,
                                               holding_overrun_flag_reg};
            pmon_pkg::OFS_FRAMING:  rdata_out <= {1'b0, hold_frame_reg};
            pmon_pkg::OFS_FLB_LOW:  rdata_out <= hold_flb_reg[7:0];
            pmon_pkg::OFS_FLB_HIGH: rdata_out <= {6'h00, hold_flb_reg[9:8]};
            pmon_pkg::OFS_BCE_LOW:  rdata_out <= hold_bce_reg[7:0];
            pmon_pkg::OFS_BCE_HIGH: rdata_out <= {6'h00, hold_bce_reg[9:8]};
            pmon_pkg::OFS_VIOL_LOW:  rdata_out <= hold_viol_reg[7:0];
            pmon_pkg::OFS_VIOL_HIGH: rdata_out <= {3'h0, hold_viol_reg[12:8]};
            default:                rdata_out <= pmon_pkg::RESET_BYTE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write sampled at edge n, latch strobe sampled at edge n+3
   a_latch_delay : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (count_wr && !latch_pend_reg) |-> ##3 latch_go)
      else $error("latch not taken within the allowed delay");
   a_transfer_set : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      latch_go |=> transfer_done_flag_reg)
      else $error("transfer flag not set by latch");
   a_overrun_set : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (latch_go && transfer_done_flag_reg) |=> holding_overrun_flag_reg)
      else $error("overrun not flagged");
   a_framing_inhibit : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (e1_mode_in && frame_loss_flag_in) |=> frame_amt_reg == 3'h0)
      else $error("framing error counted out of frame");
   a_t1_inhibit : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (!e1_mode_in && !in_frame_flag_in) |=> frame_amt_reg == 3'h0)
      else $error("T1 framing error counted while not in frame");
   a_crc_inhibit : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (e1_mode_in && multiframe_loss_flag_in) |=> bce_amt_reg == 3'h0)
      else $error("CRC error counted out of multiframe");
   a_far_inhibit : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (e1_mode_in && frame_loss_flag_in) |=> !flb_inc_reg)
      else $error("far end block error counted out of frame");
   a_exz_drop : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (excess_zero_count_disable_in && !bipolar_violation_in) |=> !viol_inc_reg)
      else $error("excess zeros counted while disabled");
   a_hold_load : assert property (@(posedge mclk_in) disable iff (!rstn_in)
      latch_go |=> hold_frame_reg == $past(framing_error_tally_reg))
      else $error("holding register missed the count");
endmodule

// file: testbench/frame_event_source.sv
`timescale 1ns/100ps
// framer status levels and line event pulses, one cycle per event
module frame_event_source (
   input  wire logic        mclk_in,
   output logic             frame_loss_out,
   output logic             in_frame_out,
   output logic             mf_loss_out,
   output logic      [10:0] pulse_out,
   output logic      [1:0]  fas_cnt_out,
   output logic      [2:0]  bit_cnt_out
);
   initial begin
      frame_loss_out = 1'h0;
      in_frame_out   = 1'h0;
      mf_loss_out    = 1'h0;
      pulse_out      = 11'h000;
      fas_cnt_out    = 2'h0;
      bit_cnt_out    = 3'h0;
   end
   // alignment state seen by the counters
   task status(input logic fls, input logic inf, input logic mfl);
      @(posedge mclk_in);
      frame_loss_out <= fls;
      in_frame_out   <= inf;
      mf_loss_out    <= mfl;
   endtask
   // n back-to-back pulses on one line, then all lines return to idle
   task fire(input int sel, input int n, input logic [2:0] v);
      repeat (n) begin
         @(posedge mclk_in);
         pulse_out   <= 11'h001 << sel;
         fas_cnt_out <= (sel == 0) ? v[1:0] : 2'h0;
         bit_cnt_out <= (sel == 7) ? v : 3'h0;
      end
      @(posedge mclk_in);
      pulse_out   <= 11'h000;
      fas_cnt_out <= 2'h0;
      bit_cnt_out <= 3'h0;
   endtask
endmodule

// file: testbench/line_error_performance_counters_tb.sv
`timescale 1ns/100ps
module line_error_performance_counters_tb;
   logic        mclk_in, rstn_in, e1_mode, word_sel, bit2_on, align_sel, ez_off, wr, rd;
   logic [7:0]  addr, wdata;
   wire  [7:0]  rdata;
   wire         irq, fls, inf, mfl;
   wire  [10:0] pulse;
   wire  [1:0]  fcnt;
   wire  [2:0]  bcnt;
   int          fails, checks;

   initial begin
      mclk_in = 1'h0;
      forever #2 mclk_in = ~mclk_in;
   end

   frame_event_source src (.mclk_in(mclk_in), .frame_loss_out(fls), .in_frame_out(inf),
      .mf_loss_out(mfl), .pulse_out(pulse), .fas_cnt_out(fcnt), .bit_cnt_out(bcnt));

   pmon_counters uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .e1_mode_in(e1_mode),
      .frame_loss_flag_in(fls), .in_frame_flag_in(inf), .multiframe_loss_flag_in(mfl),
      .fas_bit_err_in(pulse[0]), .fas_bit_err_cnt_in(fcnt), .fas_word_err_in(pulse[1]),
      .fas_word_select_in(word_sel), .nfas_bit2_zero_in(pulse[2]),
      .nfas_bit2_count_in(bit2_on), .t1_frame_bit_err_in(pulse[3]),
      .count_alignment_change_select_in(align_sel), .reframe_event_in(pulse[4]),
      .alignment_change_event_in(pulse[5]), .far_block_error_in(pulse[6]),
      .t1_bit_err_cnt_in(bcnt), .crc_err_in(pulse[8]), .bipolar_violation_in(pulse[9]),
      .excess_zero_in(pulse[10]), .excess_zero_count_disable_in(ez_off), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .transfer_irq_out(irq));

   ////////////////////////////////////////////////////////////////////////////////
   // register port access and comparisons
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge mclk_in);
      wr <= 1'h0;
   endtask
   task cmp_byte(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge mclk_in);
      addr <= a;
      rd   <= 1'h1;
      @(posedge mclk_in);
      rd <= 1'h0;
      @(posedge mclk_in);
      #1;
      checks++;
      if ((rdata & m) !== e) begin
         fails++;
         $display("ERROR %0t: reg %h read %h expected %h", $time, a, rdata, e);
      end
   endtask
   task cmp_bit(input logic g, input logic e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t: irq %b expected %b", $time, g, e);
      end
   endtask
   task cfg(input logic e1, input logic ws, input logic b2, input logic al, input logic ez);
      @(posedge mclk_in);
      e1_mode   <= e1;
      word_sel  <= ws;
      bit2_on   <= b2;
      align_sel <= al;
      ez_off    <= ez;
   endtask
   // idle so pipelined events land, latch, read soon after the transfer
   task latch(input logic [7:0] a);
      repeat (3) @(posedge mclk_in);
      wr_reg(a, 8'h00);
      repeat (2) @(posedge mclk_in);
   endtask
   task cmp_counts(input logic [6:0] frm, input logic [9:0] flb, input logic [9:0] bce,
                   input logic [12:0] viol);
      cmp_byte(pmon_pkg::OFS_FRAMING, {1'h0, frm}, 8'h7F);
      cmp_byte(pmon_pkg::OFS_FLB_LOW, flb[7:0], 8'hFF);
      cmp_byte(pmon_pkg::OFS_FLB_HIGH, {6'h00, flb[9:8]}, 8'h03);
      cmp_byte(pmon_pkg::OFS_BCE_LOW, bce[7:0], 8'hFF);
      cmp_byte(pmon_pkg::OFS_BCE_HIGH, {6'h00, bce[9:8]}, 8'h03);
      cmp_byte(pmon_pkg::OFS_VIOL_LOW, viol[7:0], 8'hFF);
      cmp_byte(pmon_pkg::OFS_VIOL_HIGH, {3'h0, viol[12:8]}, 8'h1F);
   endtask
   task complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: about twice the longest expected run
   initial begin
      repeat (20000) @(posedge mclk_in);
      fails++;
      complete_run;
   end
   // test sequence
   initial begin
      {rstn_in, e1_mode, word_sel, bit2_on, align_sel, ez_off, wr, rd} = 8'h00;
      {addr, wdata} = 16'h0000;
      repeat (10) @(posedge mclk_in);
      rstn_in <= 1'h1;
      latch(pmon_pkg::OFS_GLOBAL);
      cmp_counts(7'h00, 10'h000, 10'h000, 13'h0000);
      cmp_byte(pmon_pkg::OFS_STATUS, 8'h02, 8'h07);
      cmp_byte(pmon_pkg::OFS_STATUS, 8'h00, 8'h07);
      // t1 in frame, frame loss select
      src.status(1'h0, 1'h1, 1'h0);
      src.fire(3, 5, 3'h0);
      src.fire(4, 3, 3'h0);
      src.fire(7, 1, 3'h7);
      src.fire(7, 1, 3'h2);
      src.fire(9, 4, 3'h0);
      src.fire(10, 2, 3'h0);
      latch(pmon_pkg::OFS_FRAMING);
      cmp_counts(7'h05, 10'h003, 10'h009, 13'h0006);
      // t1 out of frame, alignment change select, excess zeros dropped
      cfg(1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
      src.status(1'h0, 1'h0, 1'h0);
      src.fire(3, 4, 3'h0);
      src.fire(4, 2, 3'h0);
      src.fire(5, 3, 3'h0);
      src.fire(9, 1, 3'h0);
      src.fire(10, 5, 3'h0);
      latch(pmon_pkg::OFS_VIOL_HIGH);
      cmp_counts(7'h00, 10'h003, 10'h000, 13'h0001);
      // e1 bit mode with non-alignment bit option, t1 bit errors ignored
      cfg(1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
      src.status(1'h0, 1'h1, 1'h0);
      src.fire(0, 2, 3'h3);
      src.fire(1, 2, 3'h0);
      src.fire(2, 3, 3'h0);
      src.fire(6, 4, 3'h0);
      src.fire(8, 5, 3'h0);
      src.fire(7, 1, 3'h7);
      latch(pmon_pkg::OFS_FLB_LOW);
      cmp_counts(7'h09, 10'h004, 10'h005, 13'h0000);
      // e1 word mode, option off
      cfg(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
      src.fire(1, 3, 3'h0);
      src.fire(0, 1, 3'h2);
      src.fire(2, 2, 3'h0);
      latch(pmon_pkg::OFS_BCE_LOW);
      cmp_counts(7'h03, 10'h000, 10'h000, 13'h0000);
      // e1 out of frame and out of multiframe
      src.status(1'h1, 1'h1, 1'h1);
      src.fire(1, 2, 3'h0);
      src.fire(6, 3, 3'h0);
      src.fire(8, 2, 3'h0);
      latch(pmon_pkg::OFS_BCE_HIGH);
      cmp_counts(7'h00, 10'h000, 10'h000, 13'h0000);
      // every count driven past its maximum
      cfg(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
      src.status(1'h0, 1'h1, 1'h0);
      src.fire(3, 130, 3'h0);
      src.fire(4, 1030, 3'h0);
      src.fire(7, 150, 3'h7);
      src.fire(9, 8200, 3'h0);
      latch(pmon_pkg::OFS_VIOL_LOW);
      cmp_counts(7'h7F, 10'h3FF, 10'h3FF, 13'h1FFF);
      // unread transfers overrun, then interrupt on transfer
      cmp_byte(pmon_pkg::OFS_STATUS, 8'h03, 8'h07);
      wr_reg(pmon_pkg::OFS_STATUS, 8'h04);
      latch(pmon_pkg::OFS_GLOBAL);
      repeat (3) @(posedge mclk_in);
      cmp_bit(irq, 1'h1);
      cmp_byte(pmon_pkg::OFS_STATUS, 8'h06, 8'h07);
      repeat (2) @(posedge mclk_in);
      cmp_bit(irq, 1'h0);
      cmp_byte(8'h60, 8'h00, 8'hFF);
      complete_run;
   end
endmodule
